// ==== design/psos_top.v ====
// Output routing, converter sync strobe and compare registers of three
// power-stage waveform controller instances behind one AHB-Lite slave.
// Assumes the waveform engines supply generator levels, counter values,
// count direction and mode, all synchronous to hclk.
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "psos_map.vh"

// Notes on behaviour
// - Instance 2 fourth output carries B when select is 0, A when 1.
// - Instance 2 third output carries A when select is 0, B when 1.
// - Ramp modes: sync field picks set/reset match of output A or B.
// - Centre mode: 00 reset-A match counting down, 01 counting up, else none.
// - Part A enable 0 leaves pin to port, 1 drives generator A.
// - Part B enable 0 leaves pin to port, 1 drives generator B.
// - Instance 2 third-output enable hands pin to port or generator.
// - Instance 2 fourth-output enable hands pin to port or generator.
// - Set-A, reset-A, set-B compares are write-only 12 bits, reset zero.
// - Reset-B compare is write-only 16 bits, reset zero.
// - Configuration and compares exist per instance; third/fourth bits only on 2.
// - Compare values continuously match the waveform counter.
// - Upper four reset-B bits give the fractional flank value.
// - High bytes go to a shared temporary; low write commits both.
module psos_top #(
    parameter NINST = 3
)
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [3*NINST-1:0] ctr_value_flat,
    input wire [NINST-1:0] ctr_down,
    input wire [2*NINST-1:0] mode_flat,
    input wire [NINST-1:0] gen_a,
    input wire [NINST-1:0] gen_b,
    input wire [NINST-1:0] fault_a,
    input wire [NINST-1:0] fault_b,
    input wire [12*NINST-1:0] counter_flat,
    input wire [NINST-1:0] port_a,
    input wire [NINST-1:0] port_b,
    input wire port_c,
    input wire port_d,
    output wire [NINST-1:0] output_a_pin,
    output wire [NINST-1:0] output_b_pin,
    output wire third_output_pin,
    output wire fourth_output_pin,
    output wire [4*NINST-1:0] match_flat,
    output wire [4*NINST-1:0] flank_frac_flat,
    output wire [NINST-1:0] adc_sync
);

    function [7:0] cfg_mask;
        input integer idx;
        begin
            cfg_mask = (idx == 2) ? `PSOS_CFG_I2_MASK : `PSOS_CFG_I01_MASK;
        end
    endfunction

    // Instance decode is shared by the read mux and the write path.
    function inst_hit;
        input [1:0] inst;
        input integer idx;
        begin
            inst_hit = (inst == idx[1:0]);
        end
    endfunction

    function is_high_byte;
        input [5:0] off;
        begin
            case (off)
                `PSOS_OFF_SAH, `PSOS_OFF_RAH, `PSOS_OFF_SBH, `PSOS_OFF_RBH:
                    is_high_byte = 1'b1;
                default:
                    is_high_byte = 1'b0;
            endcase
        end
    endfunction

    // Next value of one compare: only its own low byte write joins the halves.
    function [`PSOS_RB_W-1:0] cmp_next;
        input hit;
        input [5:0] off;
        input [5:0] low_off;
        input [`PSOS_RB_W-1:0] cur;
        input [7:0] high;
        input [7:0] low;
        begin
            if (hit && off == low_off)
                cmp_next = {high, low};
            else
                cmp_next = cur;
        end
    endfunction

    // Status word of one instance: the engine inputs it watches plus the strobe.
    function [31:0] status_word;
        input down;
        input wave_b;
        input wave_a;
        input [1:0] mode;
        input strobe;
        begin
            status_word = {26'h000_0000, down, wave_b, wave_a, mode, strobe};
        end
    endfunction

    reg ap_wr_ff;
    reg [5:0] ap_off_ff;
    reg [1:0] ap_inst_ff;
    reg [7:0] temp_ff;
    reg [7:0] nxt_temp;
    reg [7:0] cfg_ff [0:NINST-1];
    reg [`PSOS_CMP_W-1:0] sa_ff [0:NINST-1];
    reg [`PSOS_CMP_W-1:0] ra_ff [0:NINST-1];
    reg [`PSOS_CMP_W-1:0] sb_ff [0:NINST-1];
    reg [`PSOS_RB_W-1:0] rb_ff [0:NINST-1];
    reg [NINST-1:0] sync_ff;
    reg [NINST-1:0] nxt_sync;
    reg [NINST-1:0] ev_prev_ff;
    reg [NINST-1:0] nxt_ev_prev;
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;
    wire [8*NINST-1:0] nxt_cfg_flat;
    wire [16*NINST-1:0] nxt_sa_flat;
    wire [16*NINST-1:0] nxt_ra_flat;
    wire [16*NINST-1:0] nxt_sb_flat;
    wire [16*NINST-1:0] nxt_rb_flat;
    wire [NINST-1:0] sync_ev;
    wire take = hsel & hready & htrans[1];
    integer k;
    integer j;

    // The slave never waits, so every transfer finishes in one data phase.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr_ff <= 1'b0;
            ap_off_ff <= 6'h00;
            ap_inst_ff <= 2'b00;
        end
        else
        begin
            ap_wr_ff <= take & hwrite;
            ap_off_ff <= haddr[5:0];
            ap_inst_ff <= haddr[`PSOS_INST_LSB+1:`PSOS_INST_LSB];
        end
    end

    // Read data is taken at the address phase edge so that it stands for the
    // whole data phase; the compares are write-only and read as zero.
    always @*
    begin
        nxt_rdata = rdata_ff;
        if (take & ~hwrite)
        begin
            nxt_rdata = 32'h0000_0000;
            for (k = 0; k < NINST; k = k + 1)
            begin
                if (inst_hit(haddr[`PSOS_INST_LSB+1:`PSOS_INST_LSB], k))
                begin
                    if (haddr[5:0] == `PSOS_OFF_CFG)
                        nxt_rdata = {24'h00_0000, cfg_ff[k]};
                    else if (haddr[5:0] == `PSOS_OFF_STAT)
                        nxt_rdata = status_word(ctr_down[k], gen_b[k], gen_a[k],
                            mode_flat[2*k+:2], sync_ff[k]);
                end
            end
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_ff <= 32'h0000_0000;
        else
            rdata_ff <= nxt_rdata;
    end

    // High bytes park in one temporary shared by all compares; the low byte
    // write commits both halves together so the engine never sees a torn value.
    // Software must write the high byte first, or the low write picks up the
    // temporary left behind by an earlier access.
    always @*
    begin
        nxt_temp = temp_ff;
        if (ap_wr_ff && is_high_byte(ap_off_ff))
            nxt_temp = hwdata[7:0];
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            temp_ff <= 8'h00;
        else
            temp_ff <= nxt_temp;
    end

    genvar r;
    generate
        for (r = 0; r < NINST; r = r + 1)
        begin : g_next
            wire hit = ap_wr_ff & inst_hit(ap_inst_ff, r);
            wire [7:0] high12 = {4'h0, temp_ff[3:0]};
            assign nxt_cfg_flat[8*r+7:8*r] = (hit && ap_off_ff == `PSOS_OFF_CFG)
                ? (hwdata[7:0] & cfg_mask(r)) : cfg_ff[r];
            assign nxt_sa_flat[16*r+15:16*r] = cmp_next(hit, ap_off_ff, `PSOS_OFF_SAL,
                {4'h0, sa_ff[r]}, high12, hwdata[7:0]);
            assign nxt_ra_flat[16*r+15:16*r] = cmp_next(hit, ap_off_ff, `PSOS_OFF_RAL,
                {4'h0, ra_ff[r]}, high12, hwdata[7:0]);
            assign nxt_sb_flat[16*r+15:16*r] = cmp_next(hit, ap_off_ff, `PSOS_OFF_SBL,
                {4'h0, sb_ff[r]}, high12, hwdata[7:0]);
            assign nxt_rb_flat[16*r+15:16*r] = cmp_next(hit, ap_off_ff, `PSOS_OFF_RBL,
                rb_ff[r], temp_ff, hwdata[7:0]);
        end
    endgenerate

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (j = 0; j < NINST; j = j + 1)
            begin
                cfg_ff[j] <= `PSOS_CFG_RESET;
                sa_ff[j] <= 12'h000;
                ra_ff[j] <= 12'h000;
                sb_ff[j] <= 12'h000;
                rb_ff[j] <= `PSOS_CMP_RESET;
            end
        end
        else
        begin
            for (j = 0; j < NINST; j = j + 1)
            begin
                cfg_ff[j] <= nxt_cfg_flat[8*j+:8];
                sa_ff[j] <= nxt_sa_flat[16*j+:`PSOS_CMP_W];
                ra_ff[j] <= nxt_ra_flat[16*j+:`PSOS_CMP_W];
                sb_ff[j] <= nxt_sb_flat[16*j+:`PSOS_CMP_W];
                rb_ff[j] <= nxt_rb_flat[16*j+:`PSOS_RB_W];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NINST; g = g + 1)
        begin : g_inst
            wire [11:0] cnt = counter_flat[12*g+11:12*g];
            wire [1:0] mode = mode_flat[2*g+1:2*g];
            wire [1:0] sel = cfg_ff[g][`PSOS_SYNC_LO+1:`PSOS_SYNC_LO];
            wire m_sa = (cnt == sa_ff[g]);
            wire m_ra = (cnt == ra_ff[g]);
            wire m_sb = (cnt == sb_ff[g]);
            wire m_rb = (cnt == rb_ff[g][11:0]);
            reg ev;
            assign match_flat[4*g+3:4*g] = {m_rb, m_sb, m_ra, m_sa};
            assign flank_frac_flat[4*g+3:4*g] = rb_ff[g][15:12];
            always @*
            begin
                ev = 1'b0;
                if (mode == `PSOS_MODE_CENTER)
                begin
                    // A reset-A value of zero would never be met on the way down.
                    case (sel)
                        2'b00: ev = m_ra & ctr_down[g];
                        2'b01: ev = m_ra & ~ctr_down[g];
                        default: ev = 1'b0;
                    endcase
                end
                else
                begin
                    case (sel)
                        2'b00: ev = m_sa;
                        2'b01: ev = m_ra | fault_a[g];
                        2'b10: ev = m_sb;
                        default: ev = m_rb | fault_b[g];
                    endcase
                end
            end
            assign sync_ev[g] = ev;
            assign output_a_pin[g] = cfg_ff[g][`PSOS_EN_A] ? gen_a[g] : port_a[g];
            assign output_b_pin[g] = cfg_ff[g][`PSOS_EN_B] ? gen_b[g] : port_b[g];
        end
    endgenerate

    // A match lasts as long as the counter sits on the value, so only its
    // rising edge makes the strobe.
    always @*
    begin
        nxt_ev_prev = sync_ev;
        nxt_sync = sync_ev & ~ev_prev_ff;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ev_prev_ff <= {NINST{1'b0}};
            sync_ff <= {NINST{1'b0}};
        end
        else
        begin
            ev_prev_ff <= nxt_ev_prev;
            sync_ff <= nxt_sync;
        end
    end
    assign adc_sync = sync_ff;

    // The third and fourth pins exist only on instance 2, so their routing
    // sits outside the per-instance loop.
    wire [7:0] cfg2 = cfg_ff[2];
    reg third_wave;
    reg fourth_wave;
    always @*
    begin
        case (cfg2[`PSOS_SEL_C])
            1'b0: third_wave = gen_a[2];
            default: third_wave = gen_b[2];
        endcase
        case (cfg2[`PSOS_SEL_D])
            1'b0: fourth_wave = gen_b[2];
            default: fourth_wave = gen_a[2];
        endcase
    end
    assign third_output_pin = cfg2[`PSOS_EN_C] ? third_wave : port_c;
    assign fourth_output_pin = cfg2[`PSOS_EN_D] ? fourth_wave : port_d;

    wire unused_ok = &{1'b0, hsize, hwdata[31:8], ctr_value_flat};

endmodule // psos_top

`default_nettype wire

// ==== design/psos_map.vh ====
// Register map and field layout of the power-stage output select block.
// Assumes an AHB-Lite slave with 32-bit data, one register per aligned word.
`ifndef PSOS_MAP_VH
`define PSOS_MAP_VH

// Byte offsets inside one instance window.
`define PSOS_OFF_CFG 6'h00
`define PSOS_OFF_SAH 6'h04
`define PSOS_OFF_SAL 6'h08
`define PSOS_OFF_RAH 6'h0C
`define PSOS_OFF_RAL 6'h10
`define PSOS_OFF_SBH 6'h14
`define PSOS_OFF_SBL 6'h18
`define PSOS_OFF_RBH 6'h1C
`define PSOS_OFF_RBL 6'h20
`define PSOS_OFF_STAT 6'h24
// Instance index sits above the 6-bit window offset.
`define PSOS_INST_LSB 6
`define PSOS_NUM_INST 3

// Configuration register fields.
`define PSOS_EN_A 0
`define PSOS_EN_C 1
`define PSOS_EN_B 2
`define PSOS_EN_D 3
`define PSOS_SYNC_LO 4
`define PSOS_SEL_C 6
`define PSOS_SEL_D 7
`define PSOS_CFG_RESET 8'h00
`define PSOS_CFG_I01_MASK 8'h35
`define PSOS_CFG_I2_MASK 8'hFF

// Compare widths and masks.
`define PSOS_CMP_W 12
`define PSOS_RB_W 16
`define PSOS_HI12_MASK 8'h0F
`define PSOS_CMP_RESET 16'h0000

// Waveform mode encodings.
`define PSOS_MODE_CENTER 2'b11

`endif

// ==== tb/psos_props.sv ====
// Port checks for the output select block.
// Assumes a bind into psos_top, one hclk domain.
`timescale 1ns/1ps
`default_nettype none
module psos_props #(
    parameter NINST = 3
)
(
    input wire hclk,
    input wire hresetn,
    input wire [2*NINST-1:0] mode_flat,
    input wire [NINST-1:0] gen_a,
    input wire [NINST-1:0] gen_b,
    input wire [NINST-1:0] fault_a,
    input wire [NINST-1:0] fault_b,
    input wire [NINST-1:0] port_a,
    input wire [NINST-1:0] port_b,
    input wire port_c,
    input wire port_d,
    input wire [NINST-1:0] output_a_pin,
    input wire [NINST-1:0] output_b_pin,
    input wire third_output_pin,
    input wire fourth_output_pin,
    input wire [4*NINST-1:0] match_flat,
    input wire [NINST-1:0] adc_sync
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_pulse;
        adc_sync[0] ##1 !adc_sync[0];
    endsequence
    a_pin_a_src: assert property (output_a_pin[0] == gen_a[0] || output_a_pin[0] == port_a[0])
        else $error("pin a source wrong");
    a_pin_b_src: assert property (output_b_pin[1] == gen_b[1] || output_b_pin[1] == port_b[1])
        else $error("pin b source wrong");
    a_third_src: assert property (third_output_pin == gen_a[2] || third_output_pin == gen_b[2]
        || third_output_pin == port_c) else $error("third pin source wrong");
    a_fourth_src: assert property (fourth_output_pin == gen_a[2] || fourth_output_pin == gen_b[2]
        || fourth_output_pin == port_d) else $error("fourth pin source wrong");
    a_sync_pulse: assert property ($rose(adc_sync[0]) |-> s_pulse)
        else $error("strobe too long");
    a_sync_two: assert property (adc_sync[2] |=> !adc_sync[2])
        else $error("strobe two too long");
    a_sync_cause: assert property (adc_sync[0] |-> $past(|match_flat[3:0] || fault_a[0] || fault_b[0]))
        else $error("strobe without event");
    a_centre_ra: assert property (adc_sync[0] && $past(mode_flat[1:0]) == 2'b11
        |-> $past(match_flat[1])) else $error("centre strobe not from reset-a");
endmodule // psos_props
bind psos_top psos_props #(.NINST(NINST)) u_props (.hclk(hclk), .hresetn(hresetn),
    .mode_flat(mode_flat), .gen_a(gen_a), .gen_b(gen_b), .fault_a(fault_a), .fault_b(fault_b),
    .port_a(port_a), .port_b(port_b), .port_c(port_c), .port_d(port_d),
    .output_a_pin(output_a_pin), .output_b_pin(output_b_pin), .third_output_pin(third_output_pin),
    .fourth_output_pin(fourth_output_pin), .match_flat(match_flat), .adc_sync(adc_sync));
`default_nettype wire

// ==== tb/psos_adc_model.sv ====
// Converter sampler model counting strobes of instance 0.
// Assumes strobes are synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module psos_adc_model #(
    parameter NINST = 3
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [NINST-1:0] adc_sync,
    output var int samples
);
    // One conversion per strobe cycle, so a stretched strobe shows as extra samples.
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            samples <= 0;
        else if (adc_sync[0])
            samples <= samples + 1;
endmodule // psos_adc_model
`default_nettype wire

// ==== tb/test_power_stage_output_select.sv ====
// Register-level bench for the output select block.
// Assumes psos_top answers every AHB-Lite transfer with hreadyout.
`timescale 1ns/1ps
`default_nettype none
`include "psos_map.vh"
module test_power_stage_output_select;
    logic hclk = 0;
    logic hresetn = 0;
    logic hsel, hwrite, hready, hreadyout, hresp, port_c, port_d, tp, fp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, ctr_down, gen_a, gen_b, fault_a, fault_b, port_a, port_b, oa, ob, adc_sync;
    logic [8:0] ctr_value_flat;
    logic [5:0] mode_flat;
    logic [35:0] counter_flat;
    logic [11:0] match_flat, flank;
    logic [11:0] ptab [4] = '{12'h005, 12'h0fa, 12'hcf9, 12'hc05};
    logic [11:0] stab [9] = '{12'h001, 12'h105, 12'h209, 12'h301, 12'h00f, 12'h00c, 12'h10d,
        12'h20c, 12'h30e};
    int samples, base;
    int fail_count = 0;
    int total_checks = 0;
    always #12.5 hclk = ~hclk;
    assign hready = hreadyout;
    psos_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ctr_value_flat(ctr_value_flat),
        .ctr_down(ctr_down), .mode_flat(mode_flat), .gen_a(gen_a), .gen_b(gen_b),
        .fault_a(fault_a), .fault_b(fault_b), .counter_flat(counter_flat), .port_a(port_a),
        .port_b(port_b), .port_c(port_c), .port_d(port_d), .output_a_pin(oa),
        .output_b_pin(ob), .third_output_pin(tp), .fourth_output_pin(fp),
        .match_flat(match_flat), .flank_frac_flat(flank), .adc_sync(adc_sync));
    psos_adc_model u_adc (.hclk(hclk), .hresetn(hresetn), .adc_sync(adc_sync), .samples(samples));
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            @(posedge hclk);
            n++;
        end
        if (n == 50)
        begin
            fail_count++;
            report_and_stop();
        end
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task wcmp(input logic [7:0] off, input logic [15:0] v);
        ahb(1'b1, {24'h0, off}, {24'h0, v[15:8]});
        ahb(1'b1, {24'h0, off + 8'h04}, {24'h0, v[7:0]});
    endtask
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, ctr_value_flat, ctr_down, mode_flat} <= '0;
        {fault_a, fault_b, counter_flat, gen_b, port_a, port_c} <= '0;
        {gen_a, port_b, port_d, hsize} <= {7'h7f, 3'b010};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h80, 32'h0);
        chk("cfg2 reset", 32'h0, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        for (int i = 0; i < 4; i++)
        begin
            ahb(1'b1, 32'h80, {24'h0, ptab[i][11:4]});
            @(posedge hclk);
            #1 chk("pins2", {28'h0, ptab[i][3:0]}, {28'h0, oa[2], ob[2], tp, fp});
        end
        ahb(1'b1, 32'h0, 32'hff);
        ahb(1'b0, 32'h0, 32'h0);
        chk("cfg0 mask", 32'h35, rd);
        #1 chk("pins0", 32'h2, {30'h0, oa[0], ob[0]});
        wcmp(`PSOS_OFF_SAH, 16'h05a3);
        counter_flat[11:0] <= 12'h5a3;
        @(posedge hclk);
        #1 chk("match", 32'h1, {28'h0, match_flat[3:0]});
        ahb(1'b0, {26'h0, `PSOS_OFF_SAL}, 32'h0);
        chk("sa read", 32'h0, rd);
        wcmp(`PSOS_OFF_SAH, 16'h0001);
        wcmp(`PSOS_OFF_RAH, 16'h0002);
        wcmp(`PSOS_OFF_SBH, 16'h0003);
        wcmp(`PSOS_OFF_RBH, 16'hf004);
        counter_flat[11:0] <= 12'h000;
        #1 chk("flank", 32'hf, {28'h0, flank[3:0]});
        for (int k = 0; k < 9; k++)
        begin
            ahb(1'b1, 32'h0, {24'h0, stab[k][11:4]});
            mode_flat[1:0] <= stab[k][3:2];
            ctr_down[0] <= stab[k][1];
            base = samples;
            for (int c = 1; c < 8; c++)
            begin
                @(posedge hclk);
                counter_flat[11:0] <= 12'(c % 7);
            end
            repeat (3) @(posedge hclk);
            chk("sync", {31'h0, stab[k][0]}, samples - base);
        end
        for (int f = 0; f < 2; f++)
        begin
            ahb(1'b1, 32'h0, {24'h0, 2'b00, f[0], 1'b1, 4'h0});
            mode_flat[1:0] <= 2'b00;
            base = samples;
            @(posedge hclk);
            {fault_b[0], fault_a[0]} <= {f[0], ~f[0]};
            @(posedge hclk);
            {fault_b[0], fault_a[0]} <= 2'b00;
            repeat (3) @(posedge hclk);
            chk("fault sync", 32'h1, samples - base);
        end
        wcmp(8'h9c, 16'h5123);
        counter_flat[35:24] <= 12'h123;
        @(posedge hclk);
        #1 chk("match2", 32'h8, {28'h0, match_flat[11:8]});
        chk("flank2", 32'h5, {28'h0, flank[11:8]});
        report_and_stop();
    end
endmodule // test_power_stage_output_select
`default_nettype wire
